// ===== verilog/clr_pkg.sv
// Shared constants and helper functions of the camera lane receiver
package clr_pkg;

    localparam int NUM_LANES = 4;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 4;

    // Low-power line pair levels, {p, n}
    localparam logic [1:0] LP_STOP = 2'h3;
    localparam logic [1:0] LP_HS_REQ = 2'h1;
    localparam logic [1:0] LP_BRIDGE = 2'h0;

    // Lane count selector codes; any other code selects four lanes
    localparam logic [1:0] CNT_ONE_LANE = 2'h0;
    localparam logic [1:0] CNT_TWO_LANES = 2'h1;

    // Packet header fields
    localparam logic [5:0] DT_SHORT_MAX = 6'h0f;
    localparam logic [5:0] DT_FRAME_START = 6'h00;
    localparam logic [5:0] DT_FRAME_END = 6'h01;
    localparam logic [1:0] HDR_LAST = 2'h3;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;

    // Parity coverage of each header ECC bit over the 24 header bits
    localparam logic [23:0] ECC_MASK [6] = '{24'hf12cb7, 24'hf2555b, 24'h749a6d,
                                             24'hb8e38e, 24'hdf03f0, 24'heffc00};

    // Active lane mask for a lane count code
    function automatic logic [3:0] lane_mask(input logic [1:0] cnt);
        lane_mask = (cnt == CNT_ONE_LANE) ? 4'h1 : (cnt == CNT_TWO_LANES) ? 4'h3 : 4'hf;
    endfunction

    // Bytes delivered per link clock edge
    function automatic logic [2:0] lane_bytes(input logic [1:0] cnt);
        lane_bytes = (cnt == CNT_ONE_LANE) ? 3'h1 : (cnt == CNT_TWO_LANES) ? 3'h2 : 3'h4;
    endfunction

    function automatic logic [5:0] ecc_calc(input logic [23:0] d);
        logic [5:0] p;
        p = 6'h00;
        for (int k = 0; k < 6; k++)
            p[k] = ^(d & ECC_MASK[k]);
        return p;
    endfunction

    // Returns {double_err, corrected, header}; single errors are repaired
    function automatic logic [25:0] ecc_fix(input logic [23:0] d, input logic [5:0] p);
        logic [5:0] syn;
        logic [5:0] col;
        logic [23:0] fixed;
        logic hit;
        syn = ecc_calc(d) ^ p;
        fixed = d;
        hit = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            for (int k = 0; k < 6; k++)
                col[k] = ECC_MASK[k][i];
            if (syn == col)
            begin
                fixed[i] = ~d[i];
                hit = 1'b1;
            end
        end
        if (syn == 6'h00)
            return {2'h0, d};
        else if ($onehot(syn) || hit)
            return {2'h1, fixed};
        else
            return {2'h2, d};
    endfunction

    // Payload checksum, one byte, low bit first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction

endpackage

// ===== verilog/clr_lane_fsm.sv
// Low-power / high-speed state tracker for one lane
`timescale 1ns/1ps

module clr_lane_fsm (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic force_hs_in,
    input wire logic [1:0] lp_in,
    output logic hs_mode_out,
    output logic term_en_out,
    output logic sot_out,
    output logic eot_out
);

    typedef enum logic [3:0] {
        LN_STOP = 4'h1,
        LN_REQ = 4'h2,
        LN_HS = 4'h4,
        LN_EXIT = 4'h8
    } clr_lane_e;

    clr_lane_e state_r;
    clr_lane_e state_nxt;

    // Next lane state from the line levels
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            LN_STOP:
                if (lp_in == clr_pkg::LP_HS_REQ)
                    state_nxt = LN_REQ;
            LN_REQ:
                if (lp_in == clr_pkg::LP_BRIDGE)
                    state_nxt = LN_HS;
                else if (lp_in != clr_pkg::LP_HS_REQ)
                    state_nxt = LN_STOP;
            LN_HS:
                if (lp_in == clr_pkg::LP_STOP && !force_hs_in)
                    state_nxt = LN_EXIT;
            LN_EXIT:
                state_nxt = LN_STOP;
            default:
                state_nxt = LN_STOP;
        endcase
        if (!enable_in)
            state_nxt = LN_STOP;
    end

    // Lane state; escape entry is never decoded
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            state_r <= LN_STOP;
        else
            state_r <= state_nxt;
    end

    // Burst edge pulses
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            sot_out <= 1'b0;
            eot_out <= 1'b0;
        end
        else
        begin
            sot_out <= (state_r != LN_HS) && (state_nxt == LN_HS);
            eot_out <= (state_r == LN_HS) && (state_nxt != LN_HS);
        end
    end

    assign hs_mode_out = (state_r == LN_HS);
    assign term_en_out = (state_r == LN_HS);

    sequence s_entry;
        (state_r == LN_REQ && lp_in == clr_pkg::LP_HS_REQ) ##1 lp_in == clr_pkg::LP_BRIDGE;
    endsequence

    a_hs_entry_seq: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (enable_in ##0 s_entry ##0 enable_in) |=> hs_mode_out)
        else $error("lane did not enter high speed after request sequence");

    a_hs_exit_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (hs_mode_out && enable_in && lp_in == clr_pkg::LP_STOP && !force_hs_in)
        |=> (state_r == LN_EXIT && !term_en_out) ##1 (state_r == LN_STOP))
        else $error("lane skipped the exit state");

    a_hs_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (hs_mode_out && enable_in && (lp_in != clr_pkg::LP_STOP || force_hs_in))
        |=> hs_mode_out)
        else $error("lane left high speed without stop state");

endmodule // clr_lane_fsm

// ===== verilog/clr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps

module clr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_out = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_r[rd_ptr_r];

    // Storage; wrap relies on a power-of-two depth
    always_ff @(posedge ref_clk_in)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data_in;
    end

    // Pointers and fill level
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            wr_ptr_r <= push ? wr_ptr_r + AW'(1) : wr_ptr_r;
            rd_ptr_r <= pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    a_fifo_level: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (push && !pop) |=> (count_r == $past(count_r) + (AW+1)'(1)))
        else $error("fifo level did not follow a push");

endmodule // clr_fifo

// ===== verilog/clr_rx_top.sv
// Camera lane receiver: lane tracking, byte merge and packet parsing
`timescale 1ns/1ps

// Summary of operation
// - One clock lane plus one, two or four data lanes are accepted.
// - Receive only; no lane pin is ever driven by this block.
// - Escape mode is not decoded; the sensor must not use it.
// - Each data lane is either in control mode or in high speed.
// - Stop, then request, then bridge levels enter high-speed reception.
// - A lane stays in high speed until it sees the stop state.
// - Leaving high speed passes through a transition state.
// - Termination is enabled while high-speed data is received.
// - Clock lane uses the same states, entry and termination as data.
// - Continuous or gated clock-lane mode is chosen by a configuration bit.
// - In continuous mode the clock lane stays in high speed.
// - Every received packet is classified as short or long.
// - Short packets give sync events; long payload follows frame start.
// - Data types 0x00 to 0x0F are short; all others are long.
// - Long packet: id, byte count, ECC, payload bytes, 16-bit checksum.
// - Header ECC fixes single-bit errors and flags double-bit errors.
// - Payload checksum is computed, compared with footer, mismatch flagged.
module clr_rx_top (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] lane_count_in,
    input wire logic cont_clk_mode_in,
    input wire logic [1:0] clk_lp_in,
    input wire logic [7:0] data_lp_in,
    input wire logic link_clk_in,
    input wire logic [31:0] hs_byte_in,
    output logic clk_term_en_out,
    output logic [3:0] data_term_en_out,
    output logic [3:0] data_hs_mode_out,
    output logic [7:0] payload_data_out,
    output logic payload_valid_out,
    input wire logic payload_ready_in,
    output logic short_valid_out,
    output logic [7:0] short_id_out,
    output logic [15:0] short_data_out,
    output logic long_done_out,
    output logic frame_active_out,
    output logic ecc_corrected_out,
    output logic ecc_error_out,
    output logic crc_error_out,
    output logic rx_error_out
);

    typedef enum logic [3:0] {
        PS_HDR = 4'h1,
        PS_PAY = 4'h2,
        PS_CRC = 4'h4,
        PS_IDLE = 4'h8
    } clr_parse_e;

    // Two-stage pin synchroniser, first stage read only by the second
    logic [42:0] sync1_r;
    logic [42:0] sync2_r;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {hs_byte_in, link_clk_in, data_lp_in, clk_lp_in};
            sync2_r <= sync1_r;
        end
    end

    logic [1:0] clk_lp_s;
    logic [7:0] data_lp_s;
    logic link_clk_s;
    logic [31:0] hs_byte_s;

    assign clk_lp_s = sync2_r[1:0];
    assign data_lp_s = sync2_r[9:2];
    assign link_clk_s = sync2_r[10];
    assign hs_byte_s = sync2_r[42:11];

    // Lane trackers; unused lanes are held in stop
    logic [3:0] act_mask;
    logic [3:0] lane_sot;
    logic [3:0] lane_eot;
    logic clk_hs;

    assign act_mask = clr_pkg::lane_mask(lane_count_in);

    for (genvar g = 0; g < clr_pkg::NUM_LANES; g++)
    begin : g_lane
        clr_lane_fsm u_lane (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .enable_in(act_mask[g]),
            .force_hs_in(1'b0),
            .lp_in(data_lp_s[2*g +: 2]),
            .hs_mode_out(data_hs_mode_out[g]),
            .term_en_out(data_term_en_out[g]),
            .sot_out(lane_sot[g]),
            .eot_out(lane_eot[g])
        );
    end

    // Clock lane tracker, pinned in high speed in continuous mode
    clr_lane_fsm u_clk_lane (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .enable_in(1'b1),
        .force_hs_in(cont_clk_mode_in),
        .lp_in(clk_lp_s),
        .hs_mode_out(clk_hs),
        .term_en_out(clk_term_en_out),
        .sot_out(),
        .eot_out()
    );

    // Link clock edge finder; data is sampled half a period from its change
    logic link_clk_d_r;
    logic link_edge;
    logic burst;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            link_clk_d_r <= 1'b0;
        else
            link_clk_d_r <= link_clk_s;
    end

    assign burst = data_hs_mode_out[0];
    assign link_edge = link_clk_s && !link_clk_d_r && clk_hs && burst;

    // Byte staging: one word per link edge, drained one byte per cycle
    logic [31:0] word_r;
    logic [2:0] left_r;
    logic [1:0] idx_r;
    logic [7:0] byte_cur;
    logic byte_take;
    logic stall;
    logic overrun;
    logic fifo_in_ready;
    logic fifo_push;
    clr_parse_e pstate_r;
    logic frame_open_r;

    assign byte_cur = word_r[{idx_r, 3'h0} +: 8];
    assign stall = (pstate_r == PS_PAY) && frame_open_r && !fifo_in_ready;
    assign byte_take = (left_r != 3'h0) && !stall;
    assign overrun = link_edge && (left_r != 3'h0) && !(left_r == 3'h1 && byte_take);

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            word_r <= '0;
            left_r <= 3'h0;
            idx_r <= 2'h0;
        end
        else if (link_edge)
        begin
            word_r <= hs_byte_s & {{8{act_mask[3]}}, {8{act_mask[2]}},
                                   {8{act_mask[1]}}, {8{act_mask[0]}}};
            left_r <= clr_pkg::lane_bytes(lane_count_in);
            idx_r <= 2'h0;
        end
        else if (byte_take)
        begin
            left_r <= left_r - 3'h1;
            idx_r <= idx_r + 2'h1;
        end
    end

    // Burst end waits until staged bytes have drained
    logic end_pend_r;
    logic burst_end;

    assign burst_end = (end_pend_r || lane_eot[0]) && (left_r == 3'h0) && !link_edge;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            end_pend_r <= 1'b0;
        else if (burst_end || lane_sot[0])
            end_pend_r <= 1'b0;
        else if (lane_eot[0])
            end_pend_r <= 1'b1;
    end

    // Header decode from three held bytes plus the ECC byte
    logic [23:0] hdr_r;
    logic [1:0] hcnt_r;
    logic [25:0] ecc_res;
    logic [5:0] dtype;
    logic is_short;

    assign ecc_res = clr_pkg::ecc_fix(hdr_r, byte_cur[5:0]);
    assign dtype = ecc_res[5:0];
    assign is_short = (dtype <= clr_pkg::DT_SHORT_MAX);

    // Packet parser
    logic [15:0] wc_r;
    logic [15:0] crc_r;
    logic [7:0] crc_lo_r;
    logic crc_half_r;
    logic hdr_done;

    assign hdr_done = byte_take && (pstate_r == PS_HDR) && (hcnt_r == clr_pkg::HDR_LAST);

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            pstate_r <= PS_HDR;
            hdr_r <= '0;
            hcnt_r <= 2'h0;
            wc_r <= '0;
            crc_r <= clr_pkg::CRC_INIT;
            crc_lo_r <= '0;
            crc_half_r <= 1'b0;
        end
        else if (burst_end)
        begin
            pstate_r <= PS_HDR;
            hcnt_r <= 2'h0;
            crc_half_r <= 1'b0;
        end
        else if (byte_take)
        begin
            case (pstate_r)
                PS_HDR:
                begin
                    if (hcnt_r != clr_pkg::HDR_LAST)
                        hdr_r[{hcnt_r, 3'h0} +: 8] <= byte_cur; // ECC byte is not stored
                    hcnt_r <= hcnt_r + 2'h1;
                    if (hcnt_r == clr_pkg::HDR_LAST)
                    begin
                        wc_r <= ecc_res[23:8];
                        crc_r <= clr_pkg::CRC_INIT;
                        if (ecc_res[25] || is_short)
                            pstate_r <= PS_IDLE;
                        else if (ecc_res[23:8] == 16'h0000)
                            pstate_r <= PS_CRC;
                        else
                            pstate_r <= PS_PAY;
                    end
                end
                PS_PAY:
                begin
                    crc_r <= clr_pkg::crc_byte(crc_r, byte_cur);
                    wc_r <= wc_r - 16'h0001;
                    if (wc_r == 16'h0001)
                        pstate_r <= PS_CRC;
                end
                PS_CRC:
                begin
                    crc_lo_r <= byte_cur;
                    crc_half_r <= !crc_half_r;
                    if (crc_half_r)
                        pstate_r <= PS_IDLE;
                end
                PS_IDLE:
                    pstate_r <= PS_IDLE; // Trailing fill ignored until stop
                default:
                    pstate_r <= PS_IDLE;
            endcase
        end
    end

    // Frame window opened by frame start, closed by frame end
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            frame_open_r <= 1'b0;
        else if (hdr_done && !ecc_res[25] && dtype == clr_pkg::DT_FRAME_START)
            frame_open_r <= 1'b1;
        else if (hdr_done && !ecc_res[25] && dtype == clr_pkg::DT_FRAME_END)
            frame_open_r <= 1'b0;
    end

    // Short packet event and status pulses, all registered
    logic crc_done;
    logic crc_bad;

    assign crc_done = byte_take && (pstate_r == PS_CRC) && crc_half_r;
    assign crc_bad = ({byte_cur, crc_lo_r} != crc_r);

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            short_valid_out <= 1'b0;
            short_id_out <= '0;
            short_data_out <= '0;
            long_done_out <= 1'b0;
            ecc_corrected_out <= 1'b0;
            ecc_error_out <= 1'b0;
            crc_error_out <= 1'b0;
            rx_error_out <= 1'b0;
        end
        else
        begin
            short_valid_out <= hdr_done && !ecc_res[25] && is_short;
            if (hdr_done && !ecc_res[25])
            begin
                short_id_out <= ecc_res[7:0];
                short_data_out <= ecc_res[23:8];
            end
            long_done_out <= crc_done;
            ecc_corrected_out <= hdr_done && ecc_res[24];
            ecc_error_out <= hdr_done && ecc_res[25];
            crc_error_out <= crc_done && crc_bad;
            rx_error_out <= overrun || (burst_end && (pstate_r == PS_PAY
                || pstate_r == PS_CRC || (pstate_r == PS_HDR && hcnt_r != 2'h0)));
        end
    end

    assign frame_active_out = frame_open_r;

    // Payload bytes queue for the downstream consumer
    assign fifo_push = byte_take && (pstate_r == PS_PAY) && frame_open_r;

    clr_fifo #(
        .WIDTH(clr_pkg::BYTE_W),
        .DEPTH(clr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(byte_cur),
        .out_valid_out(payload_valid_out),
        .out_ready_in(payload_ready_in),
        .out_data_out(payload_data_out)
    );

    a_unused_lanes: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (data_hs_mode_out & ~act_mask) == 4'h0)
        else $error("inactive lane entered high speed");

    a_cont_clock: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (cont_clk_mode_in && clk_hs) ##1 cont_clk_mode_in |-> clk_hs)
        else $error("clock lane left high speed in continuous mode");

    a_short_class: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (hdr_done && !ecc_res[25] && dtype > clr_pkg::DT_SHORT_MAX)
        |=> !short_valid_out && pstate_r != PS_IDLE)
        else $error("long data type treated as short");

    a_crc_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (crc_done && crc_bad) |=> crc_error_out && long_done_out)
        else $error("checksum mismatch not flagged");

    a_abort_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (burst_end && pstate_r == PS_PAY) |=> rx_error_out && pstate_r == PS_HDR)
        else $error("cut packet not flagged");

    a_merge_order: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        link_edge |=> (idx_r == 2'h0) && (left_r == clr_pkg::lane_bytes($past(lane_count_in))))
        else $error("byte merge did not restart at lane zero");

endmodule // clr_rx_top

// ===== testbench/clr_sensor_model.sv
// Behavioural image sensor that drives the lane pins of the receiver
`timescale 1ns/1ps

module clr_sensor_model (
    output logic [1:0] clk_lp_out,
    output logic [7:0] data_lp_out,
    output logic link_clk_out,
    output logic [31:0] hs_byte_out
);
    logic [7:0] q [$];
    logic cont_mode = 1'b0;

    // Idle at stop; the link clock stands still outside bursts
    initial
    begin
        clk_lp_out = 2'h3;
        data_lp_out = 8'hff;
        link_clk_out = 1'b0;
        hs_byte_out = 32'h0;
    end

    // Stop straight to bridge, skipping the request level
    task automatic bad_entry();
        clk_lp_out = 2'h0;
        data_lp_out = 8'h00;
        #300;
        clk_lp_out = 2'h3;
        data_lp_out = 8'hff;
        #200;
    endtask

    // All four lanes signal entry, so an unused lane that is not ignored shows up
    task automatic burst(input int lanes, input int cut);
        int n;
        int s;
        s = q.size() - cut;
        n = (s + lanes - 1) / lanes;
        clk_lp_out = 2'h1;
        data_lp_out = 8'h55;
        #100;
        clk_lp_out = 2'h0;
        data_lp_out = 8'h00;
        #200;
        for (int w = 0; w < n; w++)
        begin
            // Bytes change while the link clock is low, noise on unused lanes
            for (int l = 0; l < 4; l++)
                hs_byte_out[8*l +: 8] = (l < lanes && w*lanes+l < s) ? q[w*lanes+l] : 8'($urandom);
            #80 link_clk_out = 1'b1;
            #80 link_clk_out = 1'b0;
        end
        #200;
        data_lp_out = 8'hff;
        if (!cont_mode)
            clk_lp_out = 2'h3;
        #200;
        q.delete();
    endtask
endmodule // clr_sensor_model

// ===== testbench/tb_clr_rx_top.sv
// Self-checking bench for the camera lane receiver
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end

module tb_clr_rx_top;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, cont_clk_mode_in = 1'b0;
    logic payload_ready_in = 1'b0, rdy_en = 1'b0;
    logic [1:0] lane_count_in = 2'h0;
    logic [1:0] clk_lp_in;
    logic [7:0] data_lp_in, payload_data_out, short_id_out, hid;
    logic [31:0] hs_byte_in;
    logic [3:0] data_term_en_out, data_hs_mode_out, act;
    logic [15:0] short_data_out, hwc;
    logic link_clk_in, clk_term_en_out, payload_valid_out, short_valid_out, long_done_out;
    logic frame_active_out, ecc_corrected_out, ecc_error_out, crc_error_out, rx_error_out;
    int fail_count = 0;
    int total_checks = 0;
    int cnt [9];
    int bad = 0;
    logic [8:0] ev;
    logic [7:0] got_q [$];
    logic [7:0] exp_q [$];

    clr_rx_top dut (.ref_clk_in, .rst_in, .lane_count_in, .cont_clk_mode_in, .clk_lp_in,
        .data_lp_in, .link_clk_in, .hs_byte_in, .clk_term_en_out, .data_term_en_out,
        .data_hs_mode_out, .payload_data_out, .payload_valid_out, .payload_ready_in,
        .short_valid_out, .short_id_out, .short_data_out, .long_done_out, .frame_active_out,
        .ecc_corrected_out, .ecc_error_out, .crc_error_out, .rx_error_out);
    clr_sensor_model sensor (.clk_lp_out(clk_lp_in), .data_lp_out(data_lp_in),
        .link_clk_out(link_clk_in), .hs_byte_out(hs_byte_in));

    // 50 MHz system clock
    initial
        forever #10 ref_clk_in = ~ref_clk_in;

    // Pulse tally and payload capture; ready wiggles at random only while draining
    always @(posedge ref_clk_in)
    begin
        act = (lane_count_in == 2'h0) ? 4'h1 : (lane_count_in == 2'h1) ? 4'h3 : 4'hf;
        ev = {data_term_en_out === act, clk_term_en_out, data_hs_mode_out[0],
              rx_error_out, ecc_error_out, ecc_corrected_out, crc_error_out, long_done_out,
              short_valid_out};
        for (int k = 0; k < 9; k++)
            cnt[k] += (ev[k] === 1'b1);
        bad += (({data_hs_mode_out, data_term_en_out} & ~{act, act}) !== 8'h0);
        if (payload_valid_out === 1'b1 && payload_ready_in)
            got_q.push_back(payload_data_out);
        #1 payload_ready_in = rdy_en & 1'($urandom);
    end

    function automatic logic [5:0] ecc(input logic [23:0] d);
        for (int k = 0; k < 6; k++)
            ecc[k] = ^(d & clr_pkg::ECC_MASK[k]);
    endfunction

    // Reflected checksum, low bit first
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ clr_pkg::CRC_POLY) : (c >> 1);
        return c;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One packet per burst; the header may be spoiled by flip, the footer by bad_sum
    task automatic send(input logic [7:0] id, input logic [15:0] wc, input int lanes,
        input logic [31:0] flip, input int cut, input logic bad_sum);
        logic [31:0] h;
        logic [15:0] c;
        logic [7:0] b;
        hid = id;
        hwc = wc;
        h = {2'h0, ecc({wc, id}), wc, id} ^ flip;
        for (int k = 0; k < 4; k++)
            sensor.q.push_back(h[8*k +: 8]);
        c = clr_pkg::CRC_INIT;
        exp_q.delete();
        if (id[5:0] > clr_pkg::DT_SHORT_MAX)
        begin
            for (int k = 0; k < wc; k++)
            begin
                b = 8'($urandom);
                exp_q.push_back(b);
                sensor.q.push_back(b);
                c = crc(c, b);
            end
            c ^= {16{bad_sum}};
            sensor.q.push_back(c[7:0]);
            sensor.q.push_back(c[15:8]);
        end
        @(posedge ref_clk_in);
        #1 lane_count_in = (lanes == 1) ? 2'h0 : (lanes == 2) ? 2'h1 : 2'(2 + $urandom % 2);
        cnt = '{default: 0};
        got_q.delete();
        sensor.burst(lanes, cut);
        @(posedge ref_clk_in);
        #1;
    endtask

    task automatic ev_chk(input logic [5:0] e);
        for (int k = 0; k < 6; k++)
            `CHK("event count", int'(e[k]), cnt[k])
        `CHK("lane term", 1'b1, cnt[8] > 0)
    endtask

    // Consumer was stalled through the burst; now drain at random pace
    task automatic drain();
        rdy_en = 1'b1;
        for (int i = 0; i < 200 && payload_valid_out !== 1'b0; i++)
            @(posedge ref_clk_in);
        `CHK("drained", 1'b0, payload_valid_out)
        if (payload_valid_out !== 1'b0)
            tally_and_finish();
        rdy_en = 1'b0;
    endtask

    task automatic pay_chk();
        `CHK("payload waiting", 1'b1, payload_valid_out)
        drain();
        `CHK("payload size", exp_q.size(), got_q.size())
        for (int k = 0; k < exp_q.size() && k < got_q.size(); k++)
            `CHK("payload byte", exp_q[k], got_q[k])
    endtask

    initial
    begin
        void'($urandom(32'h59aa));
        repeat (8) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        @(posedge ref_clk_in);
        #1 `CHK("reset outputs", 10'h0, {data_hs_mode_out, clk_term_en_out, payload_valid_out,
            short_valid_out, frame_active_out, rx_error_out, long_done_out})
        sensor.bad_entry();
        `CHK("entry without request", 0, cnt[6])
        $display("test entry order done");
        send({2'($urandom), clr_pkg::DT_FRAME_START}, 16'($urandom), 1, 0, 0, 0);
        ev_chk(6'h01);
        `CHK("short id", hid, short_id_out)
        `CHK("short data", hwc, short_data_out)
        `CHK("frame on", 1'b1, frame_active_out)
        `CHK("lane in high speed", 1'b1, cnt[6] > 0)
        `CHK("clock lane term", 1'b1, cnt[7] > 0)
        `CHK("lane term", 1'b1, cnt[8] > 0)
        `CHK("lanes back to stop", 4'h0, data_hs_mode_out)
        `CHK("clock lane gated", 1'b0, clk_term_en_out)
        $display("test frame start done");
        for (int n = 1; n <= 4; n *= 2)
        begin
            send({2'($urandom), (n == 1) ? 6'h10 : 6'(6'h11 + $urandom % 46)}, 16'h4, n, 0, 0, 0);
            ev_chk(6'h02);
            pay_chk();
            $display("test long packet lanes %0d done", n);
        end
        send({2'h1, 6'h2a}, 16'h3, 2, 32'h1 << ($urandom % 24), 0, 1);
        ev_chk(6'h0e);
        pay_chk();
        $display("test corrected header done");
        send({2'h0, 6'h02}, 16'h7, 4, 32'h201, 0, 0);
        ev_chk(6'h10);
        $display("test double error done");
        send({2'h0, 6'h2b}, 16'h4, 1, 0, 3, 0);
        ev_chk(6'h20);
        drain();
        $display("test cut packet done");
        send({2'h0, clr_pkg::DT_FRAME_END}, 16'h0, 2, 0, 0, 0);
        `CHK("frame off", 1'b0, frame_active_out)
        send({2'h0, 6'h2a}, 16'h2, 2, 0, 0, 0);
        `CHK("payload outside frame", 1'b0, payload_valid_out)
        $display("test frame end done");
        cont_clk_mode_in = 1'b1;
        sensor.cont_mode = 1'b1;
        send({2'h3, clr_pkg::DT_SHORT_MAX}, 16'($urandom), 4, 0, 0, 0);
        ev_chk(6'h01);
        `CHK("clock lane stays", 1'b1, clk_term_en_out)
        `CHK("unused lanes idle", 0, bad)
        $display("test continuous clock done");
        tally_and_finish();
    end
endmodule // tb_clr_rx_top
